// file: hdl/fcc_pkg.sv
// Purpose: shared types and constants of the compare-flags / cosine execution slice
// Assumes: stack values are held as 32-bit binary floats; tags mark empty and bad formats
// Notes:   the register map sits on an AHB-Lite slave, one aligned word per register
package fcc_pkg;

  localparam logic [7:0]  OFS_CMD      = 8'h00;
  localparam logic [7:0]  OFS_CTRL     = 8'h04;
  localparam logic [7:0]  OFS_STAT     = 8'h08;
  localparam logic [7:0]  OFS_TAG      = 8'h0C;
  localparam logic [7:0]  OFS_FAULT    = 8'h10;
  localparam logic [7:0]  OFS_STK      = 8'h20;

  localparam logic [7:0]  OP_CMP_B1    = 8'hDB;
  localparam logic [7:0]  OP_POP_B1    = 8'hDF;
  localparam logic [7:0]  OP_SIG_B2    = 8'hF0;
  localparam logic [7:0]  OP_QUIET_B2  = 8'hE8;
  localparam logic [15:0] OP_COS       = 16'hD9FF;

  localparam logic [1:0]  TAG_UNSUP    = 2'h2;
  localparam logic [1:0]  TAG_EMPTY    = 2'h3;
  localparam logic [2:0]  TOP_RST      = 3'h0;
  localparam logic [15:0] TAGS_RST     = 16'hFFFF;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
  localparam logic [1:0]  CPL_USER     = 2'h3;
  localparam logic [7:0]  CODE_ZERO    = 8'h00;

  localparam logic [7:0]  EXP_ALL      = 8'hFF;
  localparam logic [7:0]  EXP_BIAS     = 8'h7F;
  localparam logic [7:0]  COS_EXP_LIM  = 8'hBE;
  localparam logic [7:0]  COS_TINY_EXP = 8'h73;
  localparam logic [31:0] F_ONE        = 32'h3F80_0000;
  localparam logic [31:0] F_ZERO       = 32'h0000_0000;
  localparam logic [31:0] F_QNAN       = 32'hFFC0_0000;
  localparam logic [31:0] QUIET_BIT    = 32'h0040_0000;
  localparam logic [47:0] FIX_ONE      = 48'h4000_0000_0000;

  localparam logic [1:0]  HTRANS_BUSY  = 2'h1;
  localparam logic        HRESP_OKAY   = 1'b0;

  typedef struct packed {
    logic zero_flag;
    logic parity_flag;
    logic carry_flag;
  } fcc_flags_t;

  localparam fcc_flags_t ZPC_GT = 3'h0;
  localparam fcc_flags_t ZPC_LT = 3'h1;
  localparam fcc_flags_t ZPC_EQ = 3'h4;
  localparam fcc_flags_t ZPC_UN = 3'h7;

  typedef enum logic [1:0] {
    MODE_REAL = 2'h0,
    MODE_PROT = 2'h1,
    MODE_V86  = 2'h2
  } fcc_mode_t;

  typedef enum logic [3:0] {
    FLT_NONE    = 4'h0,
    FLT_INVALID = 4'h1,
    FLT_STACK   = 4'h2,
    FLT_DNA     = 4'h3,
    FLT_GP      = 4'h4,
    FLT_SS      = 4'h5,
    FLT_PAGE    = 4'h6,
    FLT_ALIGN   = 4'h7
  } fcc_fault_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h1,
    PH_EXEC = 2'h2
  } fcc_phase_t;

  typedef struct packed {
    logic [9:0] rsvd;
    logic [7:0] pf_code;
    logic       unaligned;
    logic       page_miss;
    logic       ss_limit;
    logic       null_sel;
    logic       seg_limit;
    logic       mem_op;
    logic [1:0] cpl;
    logic       ac_en;
    logic [1:0] mode;
    logic       task_switched_bit;
    logic       emulate_bit;
    logic       invalid_mask_bit;
  } fcc_ctrl_t;

  typedef struct packed {
    fcc_phase_t      phase;
    logic            ap_wr;
    logic [7:0]      ap_addr;
    logic [31:0]     hrdata;
    logic            hreadyout;
    logic [15:0]     cmd;
    fcc_ctrl_t       ctrl;
    logic [2:0]      top;
    logic [15:0]     tags;
    logic [7:0][31:0] stk;
    fcc_flags_t      flags;
    logic            c1;
    logic            c2;
    logic            flags_write;
    logic            fault_valid;
    fcc_fault_t      fault_kind;
    logic            code_valid;
    logic [7:0]      fault_code;
  } fcc_state_t;

endpackage

// file: hdl/fcc_unit.sv
// Purpose: executes the compare-and-set-integer-flags group and the cosine op
// Assumes: one AHB-Lite master; a write to the command word starts one instruction
// Notes:   stack values are 32-bit floats; cosine is a bounded short-series estimate
//
// Local design decisions: register access over AHB-Lite and the register addresses.
module fcc_unit (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output fcc_pkg::fcc_flags_t    int_flags,
  output logic                   flags_write,
  output logic                   fault_valid,
  output fcc_pkg::fcc_fault_t    fault_kind,
  output logic                   fault_code_valid,
  output logic [7:0]             fault_code
);

  fcc_pkg::fcc_state_t st;
  fcc_pkg::fcc_state_t next_st;

  function automatic logic is_nan(input logic [31:0] v);
    return (v[30:23] == fcc_pkg::EXP_ALL) && (v[22:0] != 23'h00_0000);
  endfunction

  function automatic logic is_snan(input logic [31:0] v);
    return is_nan(v) && !v[22];
  endfunction

  function automatic logic is_inf(input logic [31:0] v);
    return (v[30:23] == fcc_pkg::EXP_ALL) && (v[22:0] == 23'h00_0000);
  endfunction

  // maps a float onto an unsigned key whose order is the numeric order
  function automatic logic [31:0] ord_key(input logic [31:0] v);
    return v[31] ? ~v : (v | 32'h8000_0000);
  endfunction

  function automatic fcc_pkg::fcc_flags_t relation(input logic [31:0] a, input logic [31:0] b);
    if ((a[30:0] == 31'h0000_0000) && (b[30:0] == 31'h0000_0000)) begin
      return fcc_pkg::ZPC_EQ;
    end
    if (ord_key(a) > ord_key(b)) begin
      return fcc_pkg::ZPC_GT;
    end
    if (ord_key(a) < ord_key(b)) begin
      return fcc_pkg::ZPC_LT;
    end
    return fcc_pkg::ZPC_EQ;
  endfunction

  // q2.46 magnitude back to a float; truncates, so the result never leaves -1..+1
  function automatic logic [31:0] fix_to_float(input logic sgn, input logic [47:0] mag);
    logic [31:0] r;
    logic [47:0] nrm;
    int          p;
    r = fcc_pkg::F_ZERO;
    nrm = 48'h0000_0000_0000;
    p = -1;
    for (int k = 0; k < 48; k++) begin
      if (mag[k]) begin
        p = k;
      end
    end
    if (p >= 0) begin
      nrm = mag << (47 - p);
      r[31] = sgn;
      r[30:23] = 8'(int'(fcc_pkg::EXP_BIAS) + p - 46);
      r[22:0] = nrm[46:24];
    end
    return r;
  endfunction

  // 1 - x*x/2 for |x| < 2; larger in-domain arguments get a coarse zero
  function automatic logic [31:0] cosine(input logic [31:0] v);
    logic [23:0] xq;
    logic [47:0] half;
    xq = 24'h00_0000;
    half = 48'h0000_0000_0000;
    if (v[30:0] == 31'h0000_0000 || v[30:23] < fcc_pkg::COS_TINY_EXP) begin
      return fcc_pkg::F_ONE;
    end
    if (v[30:23] > fcc_pkg::EXP_BIAS) begin
      return fcc_pkg::F_ZERO;
    end
    xq = {1'b1, v[22:0]} >> (fcc_pkg::EXP_BIAS - v[30:23]);
    half = (48'(xq) * 48'(xq)) >> 1;
    if (half <= fcc_pkg::FIX_ONE) begin
      return fix_to_float(1'b0, fcc_pkg::FIX_ONE - half);
    end
    return fix_to_float(1'b1, half - fcc_pkg::FIX_ONE);
  endfunction

  logic [7:0]          op_b1;
  logic [7:0]          op_b2;
  logic                is_cmpi;
  logic                is_pop;
  logic                is_quiet;
  logic                is_cos;
  logic [2:0]          phys;
  logic [31:0]         opa;
  logic [31:0]         opb;
  logic                empty_any;
  logic                unsup_any;
  logic                nan_any;
  logic                snan_any;
  logic                dna;
  logic                mem_chk;
  logic                exec;
  logic                arith_go;
  logic                mask;
  fcc_pkg::fcc_mode_t  mode;

  assign op_b1     = st.cmd[15:8];
  assign op_b2     = st.cmd[7:0];
  assign is_pop    = (op_b1 == fcc_pkg::OP_POP_B1);
  assign is_quiet  = (op_b2[7:3] == fcc_pkg::OP_QUIET_B2[7:3]);
  assign is_cmpi   = (is_pop || op_b1 == fcc_pkg::OP_CMP_B1) &&
                     (is_quiet || op_b2[7:3] == fcc_pkg::OP_SIG_B2[7:3]);
  assign is_cos    = (st.cmd == fcc_pkg::OP_COS);
  assign phys      = st.top + op_b2[2:0];
  assign opa       = st.stk[st.top];
  assign opb       = is_cos ? opa : st.stk[phys];
  assign empty_any = (st.tags[2*st.top +: 2] == fcc_pkg::TAG_EMPTY) ||
                     (st.tags[2*phys +: 2] == fcc_pkg::TAG_EMPTY && !is_cos);
  assign unsup_any = (st.tags[2*st.top +: 2] == fcc_pkg::TAG_UNSUP) ||
                     (st.tags[2*phys +: 2] == fcc_pkg::TAG_UNSUP && !is_cos);
  assign nan_any   = is_nan(opa) || is_nan(opb);
  assign snan_any  = is_snan(opa) || is_snan(opb);
  assign dna       = st.ctrl.emulate_bit || st.ctrl.task_switched_bit;
  assign mem_chk   = is_cmpi && st.ctrl.mem_op;
  assign mode      = fcc_pkg::fcc_mode_t'(st.ctrl.mode);
  assign mask      = st.ctrl.invalid_mask_bit;
  assign exec      = (st.phase == fcc_pkg::PH_EXEC);
  assign arith_go  = exec && (is_cmpi || is_cos) && !dna && !mem_chk && !empty_any;

  always_comb begin
    logic [31:0] rd;
    rd = 32'h0000_0000;
    next_st = st;
    next_st.flags_write = 1'b0;
    next_st.fault_valid = 1'b0;
    unique case (haddr[7:0])
      fcc_pkg::OFS_CMD:   rd = {16'h0000, st.cmd};
      fcc_pkg::OFS_CTRL:  rd = st.ctrl;
      fcc_pkg::OFS_STAT:  rd = {23'h00_0000, exec, st.top, st.c2, st.c1, st.flags};
      fcc_pkg::OFS_TAG:   rd = {16'h0000, st.tags};
      fcc_pkg::OFS_FAULT: rd = {16'h0000, st.fault_code, 3'h0, st.code_valid, st.fault_kind};
      default: begin
        if (haddr[7:5] == fcc_pkg::OFS_STK[7:5] && haddr[1:0] == 2'h0) begin
          rd = st.stk[haddr[4:2]];
        end
      end
    endcase
    // a pipelined write whose data phase meets the exec cycle is held by hreadyout
    if (st.hreadyout && st.ap_wr) begin
      unique case (st.ap_addr)
        fcc_pkg::OFS_CMD: begin
          next_st.cmd = hwdata[15:0];
          next_st.phase = fcc_pkg::PH_EXEC;
        end
        fcc_pkg::OFS_CTRL: next_st.ctrl = fcc_pkg::fcc_ctrl_t'(hwdata);
        fcc_pkg::OFS_TAG:  next_st.tags = hwdata[15:0];
        default: begin
          if (st.ap_addr[7:5] == fcc_pkg::OFS_STK[7:5] && st.ap_addr[1:0] == 2'h0) begin
            next_st.stk[st.ap_addr[4:2]] = hwdata;
          end
        end
      endcase
    end
    if (hready) begin
      next_st.ap_wr = hsel && htrans[1] && hwrite;
      next_st.ap_addr = haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        next_st.hrdata = rd;
      end
    end
    if (exec) begin
      next_st.phase = fcc_pkg::PH_IDLE;
      next_st.fault_kind = fcc_pkg::FLT_NONE;
      next_st.code_valid = 1'b0;
      next_st.fault_code = fcc_pkg::CODE_ZERO;
      if ((is_cmpi || is_cos) && dna) begin
        next_st.fault_kind = fcc_pkg::FLT_DNA;
      end else if (mem_chk && st.ctrl.seg_limit) begin
        next_st.fault_kind = fcc_pkg::FLT_GP;
        next_st.code_valid = (mode != fcc_pkg::MODE_REAL);
      end else if (mem_chk && st.ctrl.null_sel && mode == fcc_pkg::MODE_PROT) begin
        next_st.fault_kind = fcc_pkg::FLT_GP;
        next_st.code_valid = 1'b1;
      end else if (mem_chk && st.ctrl.ss_limit) begin
        next_st.fault_kind = fcc_pkg::FLT_SS;
        next_st.code_valid = (mode != fcc_pkg::MODE_REAL);
      end else if (mem_chk && st.ctrl.page_miss && mode != fcc_pkg::MODE_REAL) begin
        next_st.fault_kind = fcc_pkg::FLT_PAGE;
        next_st.code_valid = 1'b1;
        next_st.fault_code = st.ctrl.pf_code;
      end else if (mem_chk && st.ctrl.ac_en && st.ctrl.unaligned &&
                   ((mode == fcc_pkg::MODE_PROT && st.ctrl.cpl == fcc_pkg::CPL_USER) ||
                    mode == fcc_pkg::MODE_V86)) begin
        next_st.fault_kind = fcc_pkg::FLT_ALIGN;
        next_st.code_valid = 1'b1;
      end else if (is_cmpi) begin
        // memory-operand checks passed; the register compare proceeds
        next_st.c1 = 1'b0;
        if (empty_any) begin
          next_st.fault_kind = fcc_pkg::FLT_STACK;
        end else if (is_quiet ? (snan_any || unsup_any) : (nan_any || unsup_any)) begin
          next_st.fault_kind = fcc_pkg::FLT_INVALID;
        end
        if (next_st.fault_kind == fcc_pkg::FLT_NONE) begin
          next_st.flags = nan_any ? fcc_pkg::ZPC_UN : relation(opa, opb);
          next_st.flags_write = 1'b1;
        end else if (mask) begin
          next_st.flags = fcc_pkg::ZPC_UN;
          next_st.flags_write = 1'b1;
        end
        // an unmasked fault stops the instruction: flags and stack stay
        if (is_pop && (next_st.fault_kind == fcc_pkg::FLT_NONE || mask)) begin
          next_st.tags[2*st.top +: 2] = fcc_pkg::TAG_EMPTY;
          next_st.top = st.top + 3'h1;
        end
      end else if (is_cos) begin
        next_st.c1 = 1'b0;
        next_st.c2 = 1'b0;
        if (empty_any) begin
          next_st.fault_kind = fcc_pkg::FLT_STACK;
          if (mask) begin
            next_st.stk[st.top] = fcc_pkg::F_QNAN;
          end
        end else if (is_snan(opa) || is_inf(opa) || unsup_any) begin
          next_st.fault_kind = fcc_pkg::FLT_INVALID;
          if (mask) begin
            next_st.stk[st.top] = is_snan(opa) ? (opa | fcc_pkg::QUIET_BIT) : fcc_pkg::F_QNAN;
          end
        end else if (is_nan(opa)) begin
          next_st.stk[st.top] = opa;
        end else if (opa[30:23] >= fcc_pkg::COS_EXP_LIM) begin
          next_st.c2 = 1'b1;
        end else begin
          next_st.stk[st.top] = cosine(opa);
        end
      end
      next_st.fault_valid = (next_st.fault_kind != fcc_pkg::FLT_NONE);
    end
    next_st.hreadyout = (next_st.phase != fcc_pkg::PH_EXEC);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.phase <= fcc_pkg::PH_IDLE;
      st.hreadyout <= 1'b1;
      st.ctrl <= fcc_pkg::fcc_ctrl_t'(fcc_pkg::CTRL_RST);
      st.top <= fcc_pkg::TOP_RST;
      st.tags <= fcc_pkg::TAGS_RST;
      st.fault_kind <= fcc_pkg::FLT_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata           = st.hrdata;
  assign hreadyout        = st.hreadyout;
  assign hresp            = fcc_pkg::HRESP_OKAY;
  assign int_flags        = st.flags;
  assign flags_write      = st.flags_write;
  assign fault_valid      = st.fault_valid;
  assign fault_kind       = st.fault_kind;
  assign fault_code_valid = st.code_valid;
  assign fault_code       = st.fault_code;

  dna_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && (is_cmpi || is_cos) && dna |=> fault_valid && fault_kind == fcc_pkg::FLT_DNA &&
      !flags_write && $stable(int_flags) && $stable(st.top))
    else $error("blocked op still executed");

  unmasked_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    exec && is_cmpi && !mask && (arith_go && (nan_any || unsup_any) && !is_quiet) |=>
      fault_kind == fcc_pkg::FLT_INVALID && $stable(int_flags) && $stable(st.top))
    else $error("unmasked invalid changed flags or stack");

  masked_unord_a: assert property (@(posedge hclk) disable iff (!hresetn)
    arith_go && is_cmpi && !is_quiet && mask && nan_any |=>
      fault_kind == fcc_pkg::FLT_INVALID && int_flags == fcc_pkg::ZPC_UN && flags_write)
    else $error("masked NaN compare not unordered");

  quiet_nan_a: assert property (@(posedge hclk) disable iff (!hresetn)
    arith_go && is_cmpi && is_quiet && nan_any && !snan_any && !unsup_any |=>
      !fault_valid && int_flags == fcc_pkg::ZPC_UN)
    else $error("quiet NaN compare faulted or ordered");

  pop_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
    arith_go && is_cmpi && is_pop && mask |=>
      st.top == $past(st.top) + 3'h1 && st.tags[2*$past(st.top) +: 2] == fcc_pkg::TAG_EMPTY)
    else $error("pop did not advance top");

  c1_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    flags_write |-> !st.c1 && $stable(st.c2))
    else $error("compare left condition bit one set");

  cos_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    arith_go && is_cos && !unsup_any && opa[30:0] == 31'h0000_0000 |=>
      st.stk[st.top] == fcc_pkg::F_ONE && !st.c2)
    else $error("cosine of zero not one");

  cos_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    arith_go && is_cos && !unsup_any && opa[30:23] >= fcc_pkg::COS_EXP_LIM &&
      opa[30:23] != fcc_pkg::EXP_ALL |=> st.c2 && !fault_valid && $stable(st.stk))
    else $error("out-of-domain cosine mishandled");

  exec_stall_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(exec) |-> !hreadyout ##1 (hreadyout && !exec))
    else $error("execute cycle not one stalled cycle");

endmodule

// file: test/fcc_flag_reg.sv
// Purpose: far-side model, integer flag register and fault intake of the dispatch logic
// Assumes: flags_write and fault_valid are one-cycle pulses
// Notes:   holds the last written flags and last fault kind for the bench to compare
module fcc_flag_reg (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  fcc_pkg::fcc_flags_t int_flags,
  input  wire logic          flags_write,
  input  wire logic          fault_valid,
  input  fcc_pkg::fcc_fault_t fault_kind,
  output fcc_pkg::fcc_flags_t held_flags,
  output fcc_pkg::fcc_fault_t last_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_flags <= 3'h0;
      last_fault <= fcc_pkg::FLT_NONE;
    end else begin
      // a pulse is the only qualifier: stale int_flags must not leak in
      if (flags_write) held_flags <= int_flags;
      if (fault_valid) last_fault <= fault_kind;
    end
  end
endmodule

// file: test/fcc_unit_bench.sv
// Purpose: self-checking bench for the compare-flags and cosine slice
// Assumes: single AHB-Lite master, hready tied to hreadyout
// Notes:   a queue-free reference model mirrors stack, tags, top and control
module fcc_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, flags_write, fault_valid, fcv;
  logic [31:0] haddr, hwdata, hrdata, rd, ctl;
  logic [1:0]  htrans;
  logic [2:0]  hsize, top, mflags;
  logic [7:0]  fault_code, mcode;
  logic [3:0]  mflt;
  logic [15:0] tg;
  logic [31:0] st [8];
  logic        mc1, mc2, mfw, mcv;
  logic [31:0] ctls [8] = '{32'h0000_0309, 32'h0000_0509, 32'h0000_0911, 32'h0016_9109,
                            32'h0000_21E9, 32'h0000_2129, 32'h0000_2131, 32'h0000_0301};
  int          n_errors, cmp_count;
  fcc_pkg::fcc_flags_t int_flags, held_flags;
  fcc_pkg::fcc_fault_t fault_kind, last_fault;
  logic [15:0] ops [4] = '{16'hDB_F0, 16'hDF_F0, 16'hDB_E8, 16'hDF_E8};
  logic [31:0] cosv [6] = '{32'h7F80_0001, 32'h7F80_0000, 32'h8000_0000, 32'h0000_0000,
                            32'h4100_0000, 32'h5F00_0000};
  fcc_unit fcc_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .int_flags(int_flags),
    .flags_write(flags_write), .fault_valid(fault_valid), .fault_kind(fault_kind),
    .fault_code_valid(fcv), .fault_code(fault_code));
  fcc_flag_reg fcc_flag_reg_inst (.hclk(hclk), .hresetn(hresetn), .int_flags(int_flags),
    .flags_write(flags_write), .fault_valid(fault_valid), .fault_kind(fault_kind),
    .held_flags(held_flags), .last_fault(last_fault));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  function automatic logic isnan(input logic [31:0] x);
    return x[30:23] == 8'hFF && x[22:0] != 23'h0;
  endfunction
  function automatic logic [2:0] fcmp(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] ka, kb;
    ka = a[31] ? ~a : a | 32'h8000_0000;
    kb = b[31] ? ~b : b | 32'h8000_0000;
    if ((a[30:0] == 31'h0 && b[30:0] == 31'h0) || ka == kb) return 3'h4;
    return ka > kb ? 3'h0 : 3'h1;
  endfunction
  task automatic model(input logic [15:0] op);
    logic [2:0] p;
    logic [1:0] ta, tb, md;
    logic [31:0] a, b;
    logic cmp, sig;
    sig = op[7:3] == 5'h1E;
    cmp = (op[15:8] == 8'hDB || op[15:8] == 8'hDF) && (sig || op[7:3] == 5'h1D);
    md = ctl[4:3];
    p = top + op[2:0];
    a = st[top]; b = st[p]; ta = tg[2*top+:2]; tb = tg[2*p+:2];
    mfw = 1'b0; mflt = 4'h0; mcode = 8'h0; mcv = 1'b0;
    if (!cmp && op != 16'hD9FF) return;
    if (ctl[1] | ctl[2]) begin mflt = 4'h3; return; end
    if (cmp && ctl[8]) begin
      if (ctl[9] || (ctl[10] && md == 2'h1)) mflt = 4'h4;
      else if (ctl[11]) mflt = 4'h5;
      else if (ctl[12] && md != 2'h0) begin mflt = 4'h6; mcode = ctl[21:14]; end
      else if (ctl[5] && ctl[13] && (md == 2'h2 || (md == 2'h1 && ctl[7:6] == 2'h3)))
        mflt = 4'h7;
      // page and alignment always carry a code; limit faults only outside real mode
      if (mflt != 4'h0) begin mcv = mflt > 4'h5 || md != 2'h0; return; end
    end
    if (!cmp) mc2 = 1'b0;
    if (cmp) begin
      mc1 = 1'b0;
      if (ta == 2'h3 || tb == 2'h3) mflt = 4'h2;
      else if (ta == 2'h2 || tb == 2'h2 || (isnan(a) && !a[22]) || (isnan(b) && !b[22]) ||
               (sig && (isnan(a) || isnan(b)))) mflt = 4'h1;
      if (mflt != 4'h0 && !ctl[0]) return;
      mfw = 1'b1;
      mflags = (mflt != 4'h0 || isnan(a) || isnan(b)) ? 3'h7 : fcmp(a, b);
      if (op[15:8] == 8'hDF) begin tg[2*top+:2] = 2'h3; top = top + 3'h1; end
    end else if (ta == 2'h3) begin
      mflt = 4'h2;
      if (ctl[0]) st[top] = 32'hFFC0_0000;
    end else if (ta == 2'h2 || a[30:0] == 31'h7F80_0000 || (isnan(a) && !a[22])) begin
      mflt = 4'h1;
      if (ctl[0]) st[top] = isnan(a) ? a | 32'h0040_0000 : 32'hFFC0_0000;
    end else if (!isnan(a)) begin
      mc2 = a[30:23] >= 8'hBE;
      if (!mc2) st[top] = a[30:0] == 31'h0 ? 32'h3F80_0000 : 32'h0;
    end
  endtask
  task automatic exec(input logic [15:0] op);
    bus(1'b1, 8'h00, {16'h0, op});
    model(op);
    @(posedge hclk);
    #1;
    chk(flags_write, mfw); chk(int_flags, mflags); chk(fault_kind, mflt);
    chk(fault_valid, mflt != 4'h0); chk(fault_code, mcode);
    chk(fcv, mcv);
    @(posedge hclk);
    #1;
    chk(held_flags, mflags);
    if (mflt != 4'h0) chk(last_fault, mflt);
    bus(1'b0, 8'h08, 32'h0);
    chk({rd[7:5], rd[2:0]}, {top, mflags});
    if (op != 16'hD9FF) chk(rd[3], 1'b0);
    else chk(rd[4], mc2);
    bus(1'b0, 8'h20 + 8'(top * 4), 32'h0);
    chk(rd, st[top]);
  endtask
  task automatic fill;
    for (int k = 0; k < 8; k++) bus(1'b1, 8'h20 + 8'(k * 4), st[k]);
    bus(1'b1, 8'h0C, {16'h0, tg});
  endtask
  task automatic setctl(input logic [31:0] v);
    ctl = v;
    bus(1'b1, 8'h04, v);
  endtask
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; top = 3'h0; tg = 16'hFFFF; ctl = 32'h0000_0001;
    mflags = 3'h0; mc1 = 1'b0; mc2 = 1'b0; n_errors = 0; cmp_count = 0;
    void'($urandom(32'h5edb));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h04, 0); chk(rd, 32'h0000_0001);
    bus(1'b0, 8'h0C, 0); chk(rd, 32'h0000_FFFF);
    bus(1'b1, 8'h44, 32'hFFFF_FFFF); bus(1'b0, 8'h44, 0); chk(rd, 32'h0);
    for (int n = 0; n < 32; n++) begin
      for (int k = 0; k < 8; k++)
        st[k] = {1'($urandom), 8'h7E + 8'($urandom_range(3)), 23'($urandom_range(3))};
      st[n % 8] = {n[0], 31'h0};
      tg = n[3] ? 16'($urandom) & 16'hFFAA : 16'h0;
      fill;
      exec({ops[n % 4][15:3], 3'($urandom)});
    end
    for (int n = 0; n < 24; n++) begin
      setctl({31'h0, n[0]});
      st[top] = (n % 3 == 0) ? 32'h7FC0_0001 : 32'h7F80_0001;
      tg = (n % 3 == 2) ? 16'h0002 << (2 * top) : 16'h0;
      fill;
      exec(ops[(n / 2) % 4]);
    end
    setctl(32'h0000_0003); exec(16'hDB_F1); setctl(32'h0000_0005); exec(16'hD9FF);
    foreach (ctls[j]) begin
      setctl(ctls[j]);
      tg = 16'h0; fill;
      exec(16'hDB_E9);
    end
    setctl(32'h0000_0001); exec(16'h1234);
    for (int n = 0; n < 6; n++) begin
      st[top] = cosv[n]; tg = 16'h0; fill;
      exec(16'hD9FF);
    end
    stop_test;
  end
  initial begin
    #500000;
    n_errors++;
    stop_test;
  end
endmodule
